// File: rtl/led_gpio_pin_control.sv
// Shared LED and general-purpose pin control with its register file.
`timescale 1ns/1ps
module led_gpio_pin_control (
	input  logic        i_core_clk,          // System clock, 125 MHz.
	input  logic        i_reset_n,           // Synchronous reset, active low.
	input  logic [7:0]  i_reg_addr,          // Register offset.
	input  logic        i_reg_wr_en,         // Write strobe, one cycle.
	input  logic [7:0]  i_reg_wr_data,       // Write data.
	input  logic        i_reg_rd_en,         // Read strobe, one cycle.
	output logic [7:0]  o_reg_rd_data,       // Read data, registered.
	output logic        o_reg_rd_valid,      // Read data valid pulse.
	input  logic [7:0]  i_pin_in,            // Pad levels of pins 8..1.
	output logic [10:0] o_pin_out,           // Pad output levels.
	output logic [10:0] o_pin_oe,            // Pad output enables.
	input  logic [10:0] i_lamp_invert_bit,   // Polarity per LED.
	input  logic [10:0] i_lamp_behave,       // Behaviour waveform per LED.
	input  logic [10:0] i_touch_link,        // Linked sensor touched.
	input  logic        i_group_touch,       // Sensor group touched.
	input  logic        i_lamp10_group_link, // LED10 linked to the group.
	output logic [10:0] o_lamp_actuated,     // Actuation to the engine.
	input  logic [7:0]  i_change_irq_en,     // Change interrupt enables.
	input  logic [7:0]  i_change_flag_clr,   // Change flag clear pulses.
	output logic [7:0]  o_pin_change_flag,   // Sticky change flags.
	output logic        o_irq_req            // Interrupt request level.
);

	localparam int NG = led_gpio_pkg::NUM_GPIO;
	localparam int NL = led_gpio_pkg::NUM_LAMP;

	logic [7:0]    pin_direction_r;
	logic [7:0]    pin_output_type_r;
	logic [7:0]    led_drive_low_group_r;
	logic [2:0]    led_drive_high_group_r;
	logic [7:0]    pin_change_flag_r;
	logic          irq_r;
	logic [7:0]    rd_data_r;
	logic          rd_valid_r;
	logic [7:0]    rd_data_nxt;
	logic [NL-1:0] pin_out_r;
	logic [NL-1:0] pin_oe_r;
	logic [NL-1:0] lamp_act_r;
	logic [NL-1:0] lamp_ctl;
	logic [NL-1:0] touch_eff;
	logic [NL-1:0] lamp_act;
	logic [NL-1:0] lamp_active;
	logic [NL-1:0] pin_en;
	logic [NL-1:0] pin_pp;
	logic [NL-1:0] pin_val;
	logic [NL-1:0] oe_nxt;
	logic [NL-1:0] out_nxt;
	logic          wr_hit_dir;
	logic          wr_hit_type;
	logic          wr_hit_low;
	logic          wr_hit_high;

	pin_sync_if sync_bus ();

	// Pad levels enter through the three-stage synchroniser.
	assign sync_bus.raw = i_pin_in;

	pin_level_sync u_sync (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.bus        (sync_bus)
	);

	// Write decode on the register port.
	assign wr_hit_dir  = i_reg_wr_en &&
		(i_reg_addr == led_gpio_pkg::ADDR_PIN_DIRECTION);
	assign wr_hit_type = i_reg_wr_en &&
		(i_reg_addr == led_gpio_pkg::ADDR_PIN_OUT_TYPE);
	assign wr_hit_low  = i_reg_wr_en &&
		(i_reg_addr == led_gpio_pkg::ADDR_LAMP_DRIVE_LOW);
	assign wr_hit_high = i_reg_wr_en &&
		(i_reg_addr == led_gpio_pkg::ADDR_LAMP_DRIVE_HI);

	// Direction register; every dual-use pin owns exactly one bit.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			pin_direction_r <= led_gpio_pkg::RST_PIN_DIRECTION;
		end else if (wr_hit_dir) begin
			pin_direction_r <= i_reg_wr_data;
		end
	end

	// Output type register, one bit per dual-use pin.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			pin_output_type_r <= led_gpio_pkg::RST_PIN_OUT_TYPE;
		end else if (wr_hit_type) begin
			pin_output_type_r <= i_reg_wr_data;
		end
	end

	// LED control bits; the high group keeps its three low bits only.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			led_drive_low_group_r  <= led_gpio_pkg::RST_LAMP_DRIVE_LOW;
			led_drive_high_group_r <= led_gpio_pkg::RST_LAMP_DRIVE_HI;
		end else begin
			if (wr_hit_low) begin
				led_drive_low_group_r <= i_reg_wr_data;
			end
			if (wr_hit_high) begin
				led_drive_high_group_r <= i_reg_wr_data[2:0];
			end
		end
	end

	// Read mux; the input level register and unused bits are read-only.
	always_comb begin
		unique case (i_reg_addr)
			led_gpio_pkg::ADDR_PIN_DIRECTION:  rd_data_nxt = pin_direction_r;
			led_gpio_pkg::ADDR_PIN_OUT_TYPE:   rd_data_nxt = pin_output_type_r;
			led_gpio_pkg::ADDR_PIN_IN_LEVELS:  rd_data_nxt = sync_bus.level;
			led_gpio_pkg::ADDR_LAMP_DRIVE_LOW: rd_data_nxt = led_drive_low_group_r;
			led_gpio_pkg::ADDR_LAMP_DRIVE_HI:
				rd_data_nxt = {5'h00, led_drive_high_group_r};
			default: rd_data_nxt = led_gpio_pkg::RD_UNMAPPED;
		endcase
	end

	// Read data is captured on the strobe and held; valid pulses for one cycle.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			rd_data_r  <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= i_reg_rd_en;
			if (i_reg_rd_en) begin
				rd_data_r <= rd_data_nxt;
			end
		end
	end

	// Change flags on input pins; a new change wins over a clear.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			pin_change_flag_r <= 8'h00;
		end else begin
			pin_change_flag_r <= (pin_change_flag_r & ~i_change_flag_clr) |
				(sync_bus.change & ~pin_direction_r);
		end
	end

	// Interrupt request from enabled flags of input pins.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(pin_change_flag_r & i_change_irq_en &
				~pin_direction_r);
		end
	end

	// Actuation: control bit or linked touch; LED9 rides with LED10.
	assign lamp_ctl = {led_drive_high_group_r, led_drive_low_group_r};
	always_comb begin
		touch_eff = i_touch_link;
		touch_eff[led_gpio_pkg::LAMP9_IDX] =
			i_touch_link[led_gpio_pkg::LAMP9_IDX] |
			(i_group_touch & i_lamp10_group_link);
		touch_eff = touch_eff & ~led_gpio_pkg::LAMP_NO_LINK_MASK;
	end
	assign lamp_act    = lamp_ctl | touch_eff;
	// Idle lamps sit at logic zero; actuated ones follow the engine.
	assign lamp_active = lamp_act & i_lamp_behave;

	// Per-pin drive; LED-only pins are fixed open-drain outputs.
	genvar g;
	generate
		for (g = 0; g < NL; g++) begin : g_pin
			if (g < NG) begin : g_dual
				assign pin_en[g] = pin_direction_r[g];
				assign pin_pp[g] = pin_output_type_r[g];
			end else begin : g_lamp
				assign pin_en[g] = 1'b1;
				assign pin_pp[g] = 1'b0;
			end
			// Polarity clear inverts the lamp level onto the pin.
			assign pin_val[g] = i_lamp_invert_bit[g] ?
				lamp_active[g] : ~lamp_active[g];
			// Open drain pulls low for zero and releases for one.
			assign oe_nxt[g]  = pin_en[g] & (pin_pp[g] | ~pin_val[g]);
			assign out_nxt[g] = pin_pp[g] & pin_val[g];
		end
	endgenerate

	// Pad drive and actuation outputs are registered.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			pin_out_r  <= '0;
			pin_oe_r   <= '0;
			lamp_act_r <= '0;
		end else begin
			pin_out_r  <= out_nxt;
			pin_oe_r   <= oe_nxt;
			lamp_act_r <= lamp_act;
		end
	end

	assign o_reg_rd_data     = rd_data_r;
	assign o_reg_rd_valid    = rd_valid_r;
	assign o_pin_out         = pin_out_r;
	assign o_pin_oe          = pin_oe_r;
	assign o_lamp_actuated   = lamp_act_r;
	assign o_pin_change_flag = pin_change_flag_r;
	assign o_irq_req         = irq_r;

	// Checks on the pin and register behaviour.
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);

	// An input pin is never driven on the following cycle.
	a_input_never_drives: assert property (
		1'b1 |=> ((o_pin_oe[7:0] & ~$past(pin_direction_r)) == 8'h00))
		else $error("input pin has its driver enabled");

	// Writing direction changes exactly the written bits.
	a_dir_write_bits: assert property (
		wr_hit_dir |=> (pin_direction_r == $past(i_reg_wr_data)))
		else $error("direction register did not take the write");

	// An open-drain pin never drives high.
	a_open_drain_low: assert property (
		1'b1 |=> ((o_pin_oe[7:0] & o_pin_out[7:0] &
		~$past(pin_output_type_r)) == 8'h00))
		else $error("open-drain pin driven high");

	// A push-pull output pin is always driven.
	a_push_pull_on: assert property (
		1'b1 |=> (($past(pin_direction_r) & $past(pin_output_type_r) &
		~o_pin_oe[7:0]) == 8'h00))
		else $error("push-pull output pin not driven");

	// A steady pad shows in the input level register.
	sequence s_pads_steady;
		$stable(i_pin_in)[*5];
	endsequence
	a_level_follows: assert property (
		s_pads_steady |-> (sync_bus.level == i_pin_in))
		else $error("input level does not follow a steady pad");

	// A change on input pin 1 raises its flag, then the request if enabled.
	sequence s_input_change;
		(sync_bus.change[0] && !pin_direction_r[0]);
	endsequence
	sequence s_flag_then_irq;
		o_pin_change_flag[0] ##1 (o_irq_req ||
			!$past(i_change_irq_en[0]) || $past(pin_direction_r[0]));
	endsequence
	a_change_flags: assert property (
		s_input_change |=> s_flag_then_irq)
		else $error("change flag not set on input pin");

	// The request follows enabled flags of input pins.
	a_irq_request: assert property (
		1'b1 |=> (o_irq_req == |($past(pin_change_flag_r) &
		$past(i_change_irq_en) & ~$past(pin_direction_r))))
		else $error("interrupt request disagrees with flags");

	// The high control group holds only three bits.
	a_high_ctl_write: assert property (
		wr_hit_high |=> (led_drive_high_group_r == $past(i_reg_wr_data[2:0])))
		else $error("high control group did not take the write");

	// LED-only pins drive low exactly when the active level says so.
	a_lamp_od_drive: assert property (
		1'b1 |=> (o_pin_oe[10:8] == ($past(lamp_active[10:8]) ^
		$past(i_lamp_invert_bit[10:8]))))
		else $error("LED-only pin drive disagrees with polarity");

	// LED8 and LED11 follow their control bits only.
	a_no_link_lamps: assert property (
		1'b1 |=> (o_lamp_actuated[7] == $past(led_drive_low_group_r[7]) &&
		o_lamp_actuated[10] == $past(led_drive_high_group_r[2])))
		else $error("unlinkable LED followed a sensor");

	// A touched group with LED10 linked actuates LED9.
	a_group_pairs: assert property (
		(i_group_touch && i_lamp10_group_link) |=> o_lamp_actuated[8])
		else $error("LED9 not linked with LED10 group");

	// A linked touch actuates LED1 like its control bit.
	a_touch_as_ctl: assert property (
		i_touch_link[0] |=> o_lamp_actuated[0] ##1 1'b1)
		else $error("linked touch did not actuate LED1");

	// An idle inverted LED9 pin is released.
	a_idle_released: assert property (
		(!lamp_act[8] && !i_lamp_invert_bit[8]) |=> !o_pin_oe[8])
		else $error("idle inverted LED pin is driven");

	// A write to the output type register lands whole.
	a_type_write: assert property (
		wr_hit_type |=> (pin_output_type_r == $past(i_reg_wr_data)))
		else $error("output type register did not take the write");

	// A write to the low control group lands whole.
	a_low_ctl_write: assert property (
		wr_hit_low |=> (led_drive_low_group_r == $past(i_reg_wr_data)))
		else $error("low control group did not take the write");

	// A change on any input pin sets its flag, even against a clear.
	a_flag_set_wins: assert property (
		1'b1 |=> (($past(sync_bus.change) & ~$past(pin_direction_r) &
		~o_pin_change_flag) == 8'h00))
		else $error("change on input pin lost its flag");

	// An output pin never raises a new change flag.
	a_output_no_flag: assert property (
		1'b1 |=> ((o_pin_change_flag & ~$past(pin_change_flag_r) &
		$past(pin_direction_r)) == 8'h00))
		else $error("output pin raised a change flag");

	// A set control bit always actuates its LED.
	a_ctl_actuates: assert property (
		1'b1 |=> (($past(lamp_ctl) & ~o_lamp_actuated) == 11'h000))
		else $error("set control bit left its LED idle");

	// A read of the input levels returns the settled pad levels.
	a_level_read: assert property (
		(i_reg_rd_en && (i_reg_addr == led_gpio_pkg::ADDR_PIN_IN_LEVELS))
		|=> (o_reg_rd_valid && (o_reg_rd_data == $past(sync_bus.level))))
		else $error("input level read returned a stale value");

	// A push-pull dual-use pin drives the level that polarity gives.
	a_pp_polarity: assert property (
		1'b1 |=> (((o_pin_out[7:0] ^ ~($past(lamp_active[7:0]) ^
		$past(i_lamp_invert_bit[7:0]))) & $past(pin_output_type_r)) ==
		8'h00))
		else $error("push-pull pin level disagrees with polarity");

endmodule

// File: common/led_gpio_pkg.sv
// Constants shared by the shared LED and general-purpose pin control logic.
package led_gpio_pkg;

	// Pin counts: dual-use pins first, then LED-only pins.
	localparam int NUM_GPIO = 8;
	localparam int NUM_LAMP = 11;
	localparam int NUM_HIGH = 3;

	// Register offsets on the device register port.
	localparam logic [7:0] ADDR_PIN_DIRECTION  = 8'h70;
	localparam logic [7:0] ADDR_PIN_OUT_TYPE   = 8'h71;
	localparam logic [7:0] ADDR_PIN_IN_LEVELS  = 8'h72;
	localparam logic [7:0] ADDR_LAMP_DRIVE_LOW = 8'h73;
	localparam logic [7:0] ADDR_LAMP_DRIVE_HI  = 8'h74;

	// Reset values.
	localparam logic [7:0] RST_PIN_DIRECTION  = 8'h00;
	localparam logic [7:0] RST_PIN_OUT_TYPE   = 8'h00;
	localparam logic [7:0] RST_PIN_IN_LEVELS  = 8'h00;
	localparam logic [7:0] RST_LAMP_DRIVE_LOW = 8'h00;
	localparam logic [2:0] RST_LAMP_DRIVE_HI  = 3'h0;

	// LEDs that can never follow a touch sensor (LED8 and LED11).
	localparam logic [10:0] LAMP_NO_LINK_MASK = 11'h480;
	// Bit index of LED9, which follows LED10 into the sensor group.
	localparam int LAMP9_IDX = 8;

	// Value read from an unmapped offset.
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage

// File: common/pin_sync_if.sv
// Interface between the pin control top and its input synchroniser.
`timescale 1ns/1ps
interface pin_sync_if;
	logic [led_gpio_pkg::NUM_GPIO-1:0] raw;    // Raw pad levels.
	logic [led_gpio_pkg::NUM_GPIO-1:0] level;  // Settled pad levels.
	logic [led_gpio_pkg::NUM_GPIO-1:0] change; // One-cycle change pulses.

	modport sync (input raw, output level, output change);
	modport user (output raw, input level, input change);
endinterface

// File: rtl/pin_level_sync.sv
// Three-stage synchroniser and change detector for the dual-use pad inputs.
`timescale 1ns/1ps
module pin_level_sync (
	input  logic     i_core_clk, // System clock.
	input  logic     i_reset_n,  // Synchronous reset, active low.
	pin_sync_if.sync bus         // Raw levels in, settled levels out.
);
	localparam int W = led_gpio_pkg::NUM_GPIO;

	logic [W-1:0] meta_r;
	logic [W-1:0] mid_r;
	logic [W-1:0] late_r;

	// Capture chain; the first stage is read by the second stage only.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			meta_r <= led_gpio_pkg::RST_PIN_IN_LEVELS;
			mid_r  <= led_gpio_pkg::RST_PIN_IN_LEVELS;
			late_r <= led_gpio_pkg::RST_PIN_IN_LEVELS;
		end else begin
			meta_r <= bus.raw;
			mid_r  <= meta_r;
			late_r <= mid_r;
		end
	end

	// Each bit settles once the second and third stages agree.
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic lvl_r;
			logic chg_r;
			always_ff @(posedge i_core_clk) begin
				if (!i_reset_n) begin
					lvl_r <= 1'b0;
					chg_r <= 1'b0;
				end else begin
					chg_r <= (mid_r[g] == late_r[g]) && (late_r[g] != lvl_r);
					if (mid_r[g] == late_r[g]) begin
						lvl_r <= late_r[g];
					end
				end
			end
			assign bus.level[g]  = lvl_r;
			assign bus.change[g] = chg_r;
		end
	endgenerate
endmodule

// File: sim/pad_model.sv
// Pad model with external pull-ups and an external driver on pins 8..1.
`timescale 1ns/1ps
module pad_model (
	input  logic [10:0] i_out,     // Device pad output levels.
	input  logic [10:0] i_oe,      // Device pad output enables.
	input  logic [7:0]  i_ext_val, // External driver levels.
	input  logic        i_ext_en,  // External driver active.
	output logic [7:0]  o_level    // Wire levels at pins 8..1.
);
	// Device drive wins, then the external driver, else the pull-up.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_oe[i])
				o_level[i] = i_out[i];
			else
				o_level[i] = i_ext_en ? i_ext_val[i] : 1'b1;
		end
	end
endmodule

// File: sim/tb_led_gpio_pin_control.sv
// Self-checking bench for the shared LED and general-purpose pin logic.
`timescale 1ns/1ps
module tb_led_gpio_pin_control;
	logic        clk, rst_n, wr_en, rd_en, rd_valid, grp, lnk, irq, ext_en;
	logic [7:0]  addr, wr_data, rd_data, pin_in, irq_en, clr, flag;
	logic [7:0]  ext_val, dir, typ, prev, d;
	logic [10:0] pin_out, pin_oe, pol, behave, touch, act, ctl;
	logic [10:0] eo, ee, ea;
	int          seed, err_count, checks;

	led_gpio_pin_control u_dut (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_reg_addr(addr), .i_reg_wr_en(wr_en), .i_reg_wr_data(wr_data),
		.i_reg_rd_en(rd_en), .o_reg_rd_data(rd_data),
		.o_reg_rd_valid(rd_valid), .i_pin_in(pin_in), .o_pin_out(pin_out),
		.o_pin_oe(pin_oe), .i_lamp_invert_bit(pol), .i_lamp_behave(behave),
		.i_touch_link(touch), .i_group_touch(grp),
		.i_lamp10_group_link(lnk), .o_lamp_actuated(act),
		.i_change_irq_en(irq_en), .i_change_flag_clr(clr),
		.o_pin_change_flag(flag), .o_irq_req(irq));
	pad_model u_pads (.i_out(pin_out), .i_oe(pin_oe), .i_ext_val(ext_val),
		.i_ext_en(ext_en), .o_level(pin_in));

	// Free-running 125 MHz clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic close_out();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [10:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Moves to just after the n-th next rising edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, dv);
		addr = a;
		wr_data = dv;
		wr_en = 1'b1;
		cyc(1);
		wr_en = 1'b0;
		cyc(1);
	endtask

	// Reads a register and compares it, waiting a bounded time for valid.
	task automatic rchk(input logic [7:0] a, e);
		int k;
		addr = a;
		rd_en = 1'b1;
		cyc(1);
		rd_en = 1'b0;
		for (k = 0; k < 4 && rd_valid !== 1'b1; k++) cyc(1);
		if (rd_valid !== 1'b1) begin
			err_count++;
			close_out();
		end else begin
			chk($sformatf("reg %h", a), 11'(rd_data), 11'(e));
			cyc(1);
			chk("rd_valid", 11'(rd_valid), 11'h000);
		end
	endtask

	// Lets the pads settle, then clears every change flag.
	task automatic clr_flags();
		cyc(8);
		clr = 8'hFF;
		cyc(1);
		clr = 8'h00;
		cyc(3);
		chk("flags", 11'(flag), 11'h000);
	endtask

	// Expected pad drive and actuation from the control inputs.
	function automatic void exp_drive(output logic [10:0] o, e, ac);
		logic [10:0] v;
		ac = ctl | (touch & ~led_gpio_pkg::LAMP_NO_LINK_MASK);
		ac[8] = ac[8] | (grp & lnk);
		v = ~(pol ^ (ac & behave));
		e = ~v;
		o = 11'h000;
		for (int i = 0; i < 8; i++) begin
			e[i] = dir[i] & (typ[i] | ~v[i]);
			o[i] = typ[i] & v[i];
		end
	endfunction

	initial begin
		seed = 11;
		{rst_n, wr_en, rd_en, grp, lnk, ext_en} = 6'h00;
		{addr, wr_data, irq_en, clr, ext_val} = 40'h00;
		{pol, behave, touch} = 33'h0;
		err_count = 0;
		checks = 0;
		cyc(4);
		rst_n = 1'b1;
		chk("oe", pin_oe, 11'h000);
		rchk(8'h70, 8'h00);
		rchk(8'h71, 8'h00);
		rchk(8'h73, 8'h00);
		rchk(8'h74, 8'h00);
		wr(8'h72, 8'(($random(seed))));
		wr(8'h80, 8'hA5);
		rchk(8'h72, 8'hFF);
		rchk(8'h80, 8'h00);
		d = 8'($random(seed));
		wr(8'h74, d);
		rchk(8'h74, d & 8'h07);
		// Random drive settings, first with touches on every lamp.
		for (int n = 0; n < 24; n++) begin
			{dir, typ} = 16'($random(seed));
			{ctl, pol} = 22'($random(seed));
			{behave, touch} = 22'($random(seed));
			{grp, lnk} = 2'($random(seed));
			if (n == 0) begin
				{ctl, touch, behave, grp, lnk} = {11'h0, 11'h7FF, 11'h7FF, 2'h3};
			end
			wr(8'h70, dir);
			wr(8'h71, typ);
			wr(8'h73, ctl[7:0]);
			wr(8'h74, {5'h00, ctl[10:8]});
			rchk(8'h70, dir);
			exp_drive(eo, ee, ea);
			chk("pin_out", pin_out, eo);
			chk("pin_oe", pin_oe, ee);
			chk("actuated", act, ea);
		end
		// Input pins driven from outside: levels, flags and requests.
		wr(8'h70, 8'h00);
		clr_flags();
		prev = 8'hFF;
		ext_en = 1'b1;
		for (int n = 0; n < 8; n++) begin
			{ext_val, irq_en} = 16'($random(seed));
			cyc(8);
			rchk(8'h72, ext_val);
			chk("flags", 11'(flag), 11'(ext_val ^ prev));
			chk("irq", 11'(irq), 11'(|((ext_val ^ prev) & irq_en)));
			prev = ext_val;
			clr = 8'hFF;
			cyc(1);
			clr = 8'h00;
			cyc(2);
			chk("irq", 11'(irq), 11'h000);
		end
		// Output pins: levels follow the drive, no change flags.
		ext_en = 1'b0;
		irq_en = 8'hFF;
		clr_flags();
		{pol, behave, touch, grp} = {11'h7FF, 11'h7FF, 11'h000, 1'b0};
		d = 8'($random(seed));
		wr(8'h71, 8'hFF);
		wr(8'h73, d);
		wr(8'h70, 8'hFF);
		cyc(8);
		rchk(8'h72, d);
		chk("flags", 11'(flag), 11'h000);
		chk("irq", 11'(irq), 11'h000);
		close_out();
	end
endmodule
